// ---- tic_pkg.sv ----
/*
  constants, register indices and state types for the input-capture
  channels of the second timer module.
  assumes a 32-bit apb slave where each register index sits at index*4.
*/
package tic_pkg;

  // ***********************************************************
  // register indices (byte address is four times the index)
  // ***********************************************************
  localparam logic [11:0] IDX_CH2_SC   = 12'h456;
  localparam logic [11:0] IDX_CH2_HIGH = 12'h457;
  localparam logic [11:0] IDX_CH2_LOW  = 12'h458;
  localparam logic [11:0] IDX_CH3_SC   = 12'h459;
  localparam logic [11:0] IDX_CH3_HIGH = 12'h45a;
  localparam logic [11:0] IDX_CH3_LOW  = 12'h45b;
  localparam logic [11:0] IDX_CH4_SC   = 12'h45c;
  localparam logic [11:0] IDX_CH4_HIGH = 12'h45d;
  localparam logic [11:0] IDX_CH4_LOW  = 12'h45e;
  localparam logic [11:0] IDX_CH5_SC   = 12'h45f;
  localparam logic [11:0] IDX_CH5_HIGH = 12'h460;
  localparam logic [11:0] IDX_CH5_LOW  = 12'h461;
  localparam logic [11:0] IDX_CTRL     = 12'h462;
  localparam logic [11:0] IDX_ISTS     = 12'h463;
  localparam logic [11:0] IDX_IEN      = 12'h464;
  localparam logic [11:0] IDX_ICLR     = 12'h465;
  localparam logic [11:0] CH_SPAN      = 12'h00c;
  localparam logic [1:0]  SEL_SC       = 2'h0;
  localparam logic [1:0]  SEL_HIGH     = 2'h1;
  localparam logic [1:0]  SEL_LOW      = 2'h2;

  // ***********************************************************
  // status and control field positions
  // ***********************************************************
  localparam int SC_FLAG = 7;
  localparam int SC_IE   = 6;
  localparam int SC_LINK = 5;
  localparam int SC_MODE = 4;
  localparam int SC_ELSH = 3;
  localparam int SC_ELSL = 2;

  // ***********************************************************
  // reset values and codes
  // ***********************************************************
  localparam logic [7:0] SC_RST  = 8'h00;
  localparam logic [2:0] PS_RST  = 3'h0;
  localparam logic [2:0] PS_EXT  = 3'h7;
  localparam logic [3:0] IEN_RST = 4'h0;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef struct packed {
    logic       hit;
    logic [1:0] ch;
    logic [1:0] sel;
  } tic_dec_t;

  typedef struct packed {
    logic [4:0]       sync1;
    logic [4:0]       sync2;
    logic [4:0]       prev;
    logic [6:0]       pre;
    logic [15:0]      count;
    logic [2:0]       ps;
    logic [3:0][7:0]  sc;
    logic [3:0][15:0] val;
    logic [3:0]       ists;
    logic [3:0]       ien;
    logic [31:0]      rdata;
    logic             slverr;
  } tic_state_t;

endpackage

// ---- tic_capture.sv ----
/*
  input-capture channels 2 to 5 of the second timer module, with the
  clock prescaler, the shared 16-bit counter and an apb register slave.
  assumes channel pins are asynchronous and apb runs on CORE_CLK.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns

// How it works
// - clock_divide_select picks bus clock /1../64 or channel0 pin rising edges
// - active pin edge copies the 16-bit counter into the value pair
// - two edge-select bits per channel choose rising, falling or both edges
// - capture happens whatever the flag state, overwriting the old value
// - each capture sets the channel event flag for polling
// - flag set with its irq enable set raises the interrupt request
// - reset leaves the channel value registers untouched
// - all channels use one shared 16-bit counter as time base
// - each value pair splits into high byte 15..8 and low byte 7..0
// - status/control: flag bit 7 clears on zero, enable bit 6, resets 0
// - channels 3 and 5 have no link-mode bit; bit 5 reads zero
module tic_capture
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [13:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CHANNEL0_PIN,
  input  wire logic [3:0]  CHAN_PIN,
  output logic             IRQ
);

  // ***********************************************************
  // functions
  // ***********************************************************
  function automatic tic_pkg::tic_dec_t reg_decode
  (
    input logic [11:0] idx
  );
    logic [11:0] off;
    off = idx - tic_pkg::IDX_CH2_SC;
    reg_decode.hit = (idx >= tic_pkg::IDX_CH2_SC) &&
                     (off < tic_pkg::CH_SPAN);
    reg_decode.ch  = 2'(off / 12'h003);
    reg_decode.sel = 2'(off % 12'h003);
  endfunction

  // divider output for settings 0..6; setting 0 ticks every clock
  function automatic logic div_tick
  (
    input logic [6:0] pre,
    input logic [2:0] ps
  );
    logic [6:0] mask;
    mask = 7'((8'h01 << ps) - 8'h01);
    div_tick = ((pre & mask) == mask);
  endfunction

  // odd channels (index 1 and 3 here) lack the link-mode bit
  function automatic logic [7:0] sc_view
  (
    input logic [7:0] sc,
    input int         i
  );
    sc_view = sc;
    if (i % 2 == 1)
    begin
      sc_view[tic_pkg::SC_LINK] = 1'b0;
    end
  endfunction

  // ***********************************************************
  // capture helpers
  // ***********************************************************
  // a matching edge-select bit qualifies the edge; 00 leaves the pin idle
  function automatic logic edge_hit
  (
    input logic [1:0] els,
    input logic       up,
    input logic       down
  );
    edge_hit = (els[0] && up) || (els[1] && down);
  endfunction

  // both mode bits low means input capture; other modes live elsewhere
  function automatic logic capture_mode
  (
    input logic [7:0] sc
  );
    capture_mode = (sc[tic_pkg::SC_LINK:tic_pkg::SC_MODE] == 2'h0);
  endfunction

  // counter tick from a divider tap or a synchronised count-pin edge;
  // the divider never stops, so the first period after a new select
  // may be short
  function automatic logic prescale_tick
  (
    input logic [6:0] pre,
    input logic [2:0] ps,
    input logic       ext_rise
  );
    if (ps == tic_pkg::PS_EXT)
    begin
      prescale_tick = ext_rise;
    end
    else
    begin
      prescale_tick = div_tick(pre, ps);
    end
  endfunction

  // one level request: an enabled channel flag or enabled sticky status
  function automatic logic irq_level
  (
    input logic [3:0][7:0] sc,
    input logic [3:0]      ists,
    input logic [3:0]      ien
  );
    logic any;
    any = |(ists & ien);
    for (int i = 0; i < 4; i++)
    begin
      any = any || (sc[i][tic_pkg::SC_FLAG] && sc[i][tic_pkg::SC_IE]);
    end
    irq_level = any;
  endfunction

  // ***********************************************************
  // bus helpers
  // ***********************************************************
  // flag bit only clears on a written zero; a written one is ignored
  function automatic logic [7:0] sc_write
  (
    input logic [7:0] old,
    input logic [7:0] data,
    input logic       odd
  );
    sc_write = {old[tic_pkg::SC_FLAG], data[6:0]};
    if (!data[tic_pkg::SC_FLAG])
    begin
      sc_write[tic_pkg::SC_FLAG] = 1'b0;
    end
    if (odd)
    begin
      sc_write[tic_pkg::SC_LINK] = 1'b0;
    end
  endfunction

  // read mux, sampled at the setup edge so data stands all access long
  function automatic logic [32:0] read_word
  (
    input tic_pkg::tic_state_t s,
    input tic_pkg::tic_dec_t   d,
    input logic [11:0]         i,
    input logic                ok
  );
    logic [31:0] data;
    logic        err;
    data = 32'h0000_0000;
    err  = 1'b0;
    if (!ok)
    begin
      err = 1'b1;
    end
    else if (d.hit)
    begin
      unique case (d.sel)
        tic_pkg::SEL_SC:
        begin
          data[7:0] = sc_view(s.sc[d.ch], int'(d.ch));
        end
        tic_pkg::SEL_HIGH:
        begin
          data[7:0] = s.val[d.ch][15:8];
        end
        default:
        begin
          data[7:0] = s.val[d.ch][7:0];
        end
      endcase
    end
    else if (i == tic_pkg::IDX_CTRL)
    begin
      data[2:0] = s.ps;
    end
    else if (i == tic_pkg::IDX_ISTS)
    begin
      data[3:0] = s.ists;
    end
    else if (i == tic_pkg::IDX_IEN)
    begin
      data[3:0] = s.ien;
    end
    else if (i != tic_pkg::IDX_ICLR)
    begin
      // unmapped index: error, and the data reads as zero
      err = 1'b1;
    end
    read_word = {err, data};
  endfunction

  // ***********************************************************
  // state
  // ***********************************************************
  tic_pkg::tic_state_t r;
  tic_pkg::tic_state_t next_r;
  tic_pkg::tic_dec_t   dec;
  logic [4:0]          rise;
  logic [4:0]          fall;
  logic                tick;
  logic                setup;
  logic                wr;
  logic                aligned;
  logic [11:0]         idx;

  // ***********************************************************
  // bus decode
  // ***********************************************************
  // index map: 0x456..0x461 are channels 2..5 in groups of three
  // (status/control, value high, value low); 0x462..0x465 hold the
  // prescale select, status, enable and clear; anything else errors
  // and a misaligned address errors as well
  assign idx     = PADDR[13:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  assign dec     = reg_decode(idx);
  assign setup   = PSEL && !PENABLE;
  assign wr      = PSEL && PENABLE && PWRITE;

  // ***********************************************************
  // edge detection
  // ***********************************************************
  // edges come only from the second sync stage and its delayed copy
  assign rise = r.sync2 & ~r.prev;
  assign fall = ~r.sync2 & r.prev;

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    next_r = r;
    tick   = 1'b0;
    // ***********************************************************
    // synchronisers
    // ***********************************************************
    // two-stage synchroniser for every pin; one stage could hand a
    // metastable level straight to the edge logic
    next_r.sync1 = {CHAN_PIN, CHANNEL0_PIN};
    next_r.sync2 = r.sync1;
    next_r.prev  = r.sync2;

    // ***********************************************************
    // prescaler and counter
    // ***********************************************************
    // prescaler: free running, the select only picks a tap
    next_r.pre = r.pre + 7'h01;
    tick = prescale_tick(r.pre, r.ps, rise[0]);
    // one counter serves every channel, so captures share a time base
    if (tick)
    begin
      next_r.count = r.count + 16'h0001;
    end

    // ***********************************************************
    // register reads
    // ***********************************************************
    // read data and error latched in the setup cycle
    if (setup)
    begin
      {next_r.slverr, next_r.rdata} = read_word(r, dec, idx, aligned);
    end

    // ***********************************************************
    // register writes
    // ***********************************************************
    // writes take effect at the access edge
    if (wr && aligned)
    begin
      if (dec.hit)
      begin
        unique case (dec.sel)
          tic_pkg::SEL_SC:
          begin
            next_r.sc[dec.ch] = sc_write(r.sc[dec.ch], PWDATA[7:0],
                                         dec.ch[0]);
          end
          tic_pkg::SEL_HIGH:
          begin
            next_r.val[dec.ch][15:8] = PWDATA[7:0];
          end
          default:
          begin
            next_r.val[dec.ch][7:0] = PWDATA[7:0];
          end
        endcase
      end
      else if (idx == tic_pkg::IDX_CTRL)
      begin
        next_r.ps = PWDATA[2:0];
      end
      else if (idx == tic_pkg::IDX_IEN)
      begin
        next_r.ien = PWDATA[3:0];
      end
      else if (idx == tic_pkg::IDX_ICLR)
      begin
        next_r.ists = r.ists & ~PWDATA[3:0];
      end
    end

    // ***********************************************************
    // captures
    // ***********************************************************
    // captures come last so a same-cycle event beats a clear or write
    for (int i = 0; i < 4; i++)
    begin
      logic [1:0] els;
      logic       hit;
      els = r.sc[i][tic_pkg::SC_ELSH:tic_pkg::SC_ELSL];
      hit = edge_hit(els, rise[i + 1], fall[i + 1]);
      // input capture mode: both mode bits low, edge select non-zero
      if (hit && capture_mode(r.sc[i]))
      begin
        next_r.val[i] = r.count;
        // no flag check: older value is lost if not yet read
        next_r.sc[i][tic_pkg::SC_FLAG] = 1'b1;
        next_r.ists[i] = 1'b1;
      end
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge CORE_CLK)
  begin
    r <= next_r;
    if (!RESET_N)
    begin
      // value pairs deliberately keep their contents; sync stages reset
      // low to match the idle pin level, so no false edge follows reset
      r.sync1  <= 5'h00;
      r.sync2  <= 5'h00;
      r.prev   <= 5'h00;
      r.pre    <= 7'h00;
      r.count  <= 16'h0000;
      r.ps     <= tic_pkg::PS_RST;
      r.sc     <= {4{tic_pkg::SC_RST}};
      r.ists   <= 4'h0;
      r.ien    <= tic_pkg::IEN_RST;
      r.rdata  <= 32'h0000_0000;
      r.slverr <= 1'b0;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // zero wait states: every access completes in its first cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && r.slverr;
  assign PRDATA  = r.rdata;
  assign IRQ     = irq_level(r.sc, r.ists, r.ien);

endmodule

// ---- tic_capture_chk.sv ----
/*
  port checker for tic_capture: apb answers, read data and irq.
  assumes one clock domain and binding to every tic_capture.
*/
`timescale 1ns/1ns
module tic_capture_chk
(
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [3:0]  CHAN_PIN,
  input wire logic        IRQ
);
  // *****
  // helpers
  // *****
  logic acc;
  logic bad;
  assign acc = PSEL && PENABLE;
  assign bad = PADDR[1:0] != 2'h0 || PADDR[13:2] < tic_pkg::IDX_CH2_SC
               || PADDR[13:2] > tic_pkg::IDX_ICLR;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // *****
  // properties
  // *****
  rdy_high_a: assert property (PREADY) else $error("pready low");
  err_access_a: assert property (PSLVERR |-> acc)
    else $error("slave error outside access");
  err_map_a: assert property (acc |-> PSLVERR == bad)
    else $error("slave error wrong for address");
  rst_clear_a: assert property ($rose(RESET_N) |->
    !IRQ && PRDATA == 32'h0)
    else $error("outputs not clear after reset");
  rdata_hold_a: assert property (!$past(PSEL && !PENABLE) |-> $stable(PRDATA))
    else $error("read data moved outside setup");
  // irq can only rise three clocks after a pin edge, or after a write
  irq_rise_a: assert property ($rose(IRQ) |->
    $past(CHAN_PIN, 3) != $past(CHAN_PIN, 4) || $past(acc && PWRITE))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(IRQ) |-> $past(acc && PWRITE))
    else $error("irq fell without write");
  top_zero_a: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  link_zero_a: assert property (acc && !PWRITE &&
    (PADDR == {tic_pkg::IDX_CH3_SC, 2'h0} ||
     PADDR == {tic_pkg::IDX_CH5_SC, 2'h0}) |-> !PRDATA[5])
    else $error("link bit set on odd channel");
endmodule

bind tic_capture tic_capture_chk u_chk (.CORE_CLK(CORE_CLK),
  .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CHAN_PIN(CHAN_PIN), .IRQ(IRQ));

// ---- tic_pin_model.sv ----
/*
  external pin source: four capture pins and the count pin.
  assumes the bench holds each level for at least four clocks.
*/
`timescale 1ns/1ns
module tic_pin_model
(
  input  wire logic       clk,
  input  wire logic [4:0] want,
  input  wire logic       lag,
  output logic      [4:0] pins
);
  logic       hold = 1'h0;
  logic [4:0] lvl  = 5'h00;
  assign pins = lvl;
  // slow mode adds one clock; every edge shifts alike, so spacing holds
  always @(posedge clk)
    if (want == pins)
      hold <= lag;
    else if (hold)
      hold <= 1'h0;
    else
      lvl <= want;
endmodule

// ---- test_tic_capture.sv ----
/*
  self-checking bench for tic_capture: registers, edges, rates, irq.
  assumes tic_pin_model drives the pins and the checker is bound.
*/
`timescale 1ns/1ns
module test_tic_capture;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0;
  logic        pwr = 1'h0, lag = 1'h0, pready, pslverr, irq, serr;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [4:0]  want = 5'h0, pins;
  logic [15:0] v, w, vs[4];
  int          errors = 0, num_checks = 0, seed = 32'h7bb2, e;
  tic_capture dut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CHANNEL0_PIN(pins[4]), .CHAN_PIN(pins[3:0]), .IRQ(irq));
  tic_pin_model pm (.clk(clk), .want(want), .lag(lag), .pins(pins));
  initial forever #2 clk = ~clk;
  // *****
  // tasks
  // *****
  task print_verdict;
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, g, x);
    end
  endtask
  task apb(input logic wr, input logic [11:0] i, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= wr;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    r = prdata;
    serr = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task rdc(input logic [11:0] i, input logic [31:0] x);
    apb(1'h0, i, 32'h0);
    chk(r, x);
  endtask
  function automatic logic [11:0] sc(input int c);
    return tic_pkg::IDX_CH2_SC + 12'(3 * c);
  endfunction
  // flag ignores written ones; odd channels lose the link bit
  function automatic logic [31:0] exp_sc(input int c, input logic [7:0] d);
    return {24'h0, d & 8'h7f & (c % 2 == 1 ? 8'hdf : 8'hff)};
  endfunction
  function automatic logic [15:0] tick_diff(input int p);
    return p == 7 ? 16'h7 : 16'(64 >> p);
  endfunction
  task rval(input int c, output logic [15:0] q);
    apb(1'h0, sc(c) + 12'h1, 32'h0);
    q[15:8] = r[7:0];
    apb(1'h0, sc(c) + 12'h2, 32'h0);
    q[7:0] = r[7:0];
  endtask
  task pin(input int b, input logic l);
    want[b] <= l;
    repeat (8) @(posedge clk);
  endtask
  // *****
  // sequence
  // *****
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rdc(tic_pkg::IDX_CTRL, 32'h0);
    rdc(tic_pkg::IDX_IEN, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      rdc(sc(c), 32'h0);
      apb(1'h1, sc(c), 32'hff);
      rdc(sc(c), exp_sc(c, 8'hff));
      vs[c] = 16'($random(seed));
      apb(1'h1, sc(c) + 12'h1, {24'h0, vs[c][15:8]});
      apb(1'h1, sc(c) + 12'h2, {24'h0, vs[c][7:0]});
    end
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      rval(c, w);
      chk(w, vs[c]);
      rdc(sc(c), 32'h0);
    end
    for (e = 0; e < 4; e++)
    begin
      apb(1'h1, sc(1), 32'(e << 2));
      pin(1, 1'h1);
      rdc(tic_pkg::IDX_ISTS, 32'(e % 2) << 1);
      apb(1'h1, tic_pkg::IDX_ICLR, 32'h2);
      pin(1, 1'h0);
      rdc(tic_pkg::IDX_ISTS, 32'(e / 2) << 1);
      apb(1'h1, tic_pkg::IDX_ICLR, 32'h2);
    end
    apb(1'h1, sc(0), 32'h4);
    apb(1'h1, sc(2), 32'h4);
    for (e = 0; e < 8; e++)
    begin
      lag <= 1'($random(seed));
      want <= 5'h0;
      apb(1'h1, tic_pkg::IDX_CTRL, 32'(e));
      repeat (8) @(posedge clk);
      want[0] <= 1'h1;
      repeat (4) @(posedge clk);
      repeat (7)
      begin
        want[4] <= 1'h1;
        repeat (4) @(posedge clk);
        want[4] <= 1'h0;
        repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      want[2] <= 1'h1;
      repeat (8) @(posedge clk);
      rval(0, v);
      rval(2, w);
      chk(w - v, tick_diff(e));
    end
    apb(1'h1, sc(3), 32'h4);
    pin(3, 1'h1);
    chk(irq, 32'h0);
    rdc(sc(3), 32'h84);
    apb(1'h1, tic_pkg::IDX_IEN, 32'h8);
    chk(irq, 32'h1);
    apb(1'h1, tic_pkg::IDX_ICLR, 32'h8);
    chk(irq, 32'h0);
    rdc(tic_pkg::IDX_ISTS, 32'h5);
    apb(1'h1, sc(3), 32'hcc);
    chk(irq, 32'h1);
    apb(1'h1, sc(3), 32'h4c);
    chk(irq, 32'h0);
    pin(3, 1'h0);
    chk(irq, 32'h1);
    apb(1'h0, 12'h466, 32'h0);
    chk({serr, r[30:0]}, 32'h80000000);
    print_verdict;
  end
endmodule
